// File: include/tcpfs_pkg.sv
// Constants, types and carriers for the test clock pin function select block
package tcpfs_pkg;

  // ****************************************************************
  // Pin function register layout
  // ****************************************************************
  localparam int REG_W   = 8;  // Width of the pin function register
  localparam int SEL_MSB = 7;  // Select field upper bit
  localparam int SEL_LSB = 6;  // Select field lower bit
  localparam int SEL_W   = SEL_MSB - SEL_LSB + 1;

  // ****************************************************************
  // Pin functions carried by the select field
  // ****************************************************************
  typedef enum logic [1:0] {
    FN_TEST_CLOCK    = 2'h0,  // Boundary-scan test clock
    FN_TIMER_CAPTURE = 2'h1,  // Timer capture input
    FN_SYNC          = 2'h2,  // Synchronisation signal
    FN_PWM0          = 2'h3   // PWM channel zero
  } tcpfs_fn_e;

  // Reset value of the select field keeps debug access closed
  localparam tcpfs_fn_e SEL_RESET = FN_SYNC;

  // Bits of the pin function register outside the field read as zero
  localparam logic [REG_W-1:0] REG_RESERVED_VALUE = 8'h00;

  // Synchroniser depth plus output register, in clock cycles
  localparam int PIN_LATENCY = 3;

  // ****************************************************************
  // Write request carrier
  // ****************************************************************
  typedef struct packed {
    logic             valid;  // One-cycle write strobe
    logic [REG_W-1:0] data;   // Full pin function register image
  } tcpfs_wr_s;

  // Pull the select field out of a register image
  function automatic tcpfs_fn_e tcpfs_field(input logic [REG_W-1:0] image);
    tcpfs_field = tcpfs_fn_e'(image[SEL_MSB:SEL_LSB]);
  endfunction : tcpfs_field

  // Place a select value into a register image
  function automatic logic [REG_W-1:0] tcpfs_image(input tcpfs_fn_e fn);
    logic [REG_W-1:0] image;
    image                  = REG_RESERVED_VALUE;
    image[SEL_MSB:SEL_LSB] = fn;
    tcpfs_image            = image;
  endfunction : tcpfs_image

endpackage : tcpfs_pkg

// File: logic/tcpfs_top.sv
// Function select for the shared boundary-scan test clock pin
`timescale 1ns/10ps

module tcpfs_top #(
  parameter bit BOOT_REOPENS_DEBUG = 1'b1  // Later variants reopen debug on bad checksum
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire tcpfs_pkg::tcpfs_wr_s    app_write,
  input  wire tcpfs_pkg::tcpfs_wr_s    host_write,
  input  wire logic                    boot_checksum_bad,
  input  wire logic                    pwm0_drive,
  input  wire logic                    pin_in,
  output logic [tcpfs_pkg::REG_W-1:0]  pin_function_register,
  output logic                         debug_access_enable,
  output logic                         debug_test_clock,
  output logic                         timer_capture_input,
  output logic                         sync_input,
  output logic                         pin_out,
  output logic                         pin_oe
);
  import tcpfs_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcpfs_fn_e sel;
  tcpfs_fn_e next_sel;
  logic      pin_s1;
  logic      pin_s2;
  logic      boot_clear;
  tcpfs_fn_e host_fn;
  tcpfs_fn_e app_fn;
  logic      route_test_clock;
  logic      route_capture;
  logic      route_sync;
  logic      route_pwm0;

  // ****************************************************************
  // Select field update
  // ****************************************************************

  // Write sources decoded; the host wins, then the boot loader, then the application.
  // Writes resolve in one cycle and none is held over, so firmware must repeat an
  // application write that lost to the host or the boot loader in the same cycle.
  assign host_fn    = tcpfs_field(host_write.data);
  assign app_fn     = tcpfs_field(app_write.data);
  assign boot_clear = BOOT_REOPENS_DEBUG && boot_checksum_bad;
  assign next_sel   = host_write.valid ? host_fn :
                      boot_clear       ? FN_TEST_CLOCK :
                      app_write.valid  ? app_fn :
                      sel;

  // Select field register, sync function after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sel <= SEL_RESET;
    end else begin
      sel <= next_sel;
    end
  end

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************

  // Two flops before any logic looks at the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // ****************************************************************
  // Function routing
  // ****************************************************************

  // Decode of the coming select value so outputs line up with the field
  assign route_test_clock = (next_sel == FN_TEST_CLOCK);
  assign route_capture    = (next_sel == FN_TIMER_CAPTURE);
  assign route_sync       = (next_sel == FN_SYNC);
  assign route_pwm0       = (next_sel == FN_PWM0);

  // Registered outputs; unselected functions see a quiet low level
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_function_register <= tcpfs_image(SEL_RESET);
      debug_access_enable   <= 1'b0;
      debug_test_clock      <= 1'b0;
      timer_capture_input   <= 1'b0;
      sync_input            <= 1'b0;
      pin_out               <= 1'b0;
      pin_oe                <= 1'b0;
    end else begin
      pin_function_register <= tcpfs_image(next_sel);
      debug_access_enable   <= route_test_clock;
      debug_test_clock      <= route_test_clock & pin_s2;
      timer_capture_input   <= route_capture & pin_s2;
      sync_input            <= route_sync & pin_s2;
      pin_out               <= route_pwm0 & pwm0_drive;  // Only PWM drives the pin
      pin_oe                <= route_pwm0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Cycles since reset release, saturating, so pin history is trusted;
  // the synchroniser restarts from low after reset, so early cycles are skipped
  logic [1:0] settle_cnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_cnt <= 2'h0;
    end else if (settle_cnt != 2'h3) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  // Host asks for the test clock function
  sequence host_zero_s;
    host_write.valid && (host_write.data[SEL_MSB:SEL_LSB] == FN_TEST_CLOCK);
  endsequence

  // Debug opened with the register image agreeing
  sequence debug_open_s;
    (sel == FN_TEST_CLOCK) && debug_access_enable &&
      (pin_function_register[SEL_MSB:SEL_LSB] == 2'h0);
  endsequence

  // Boot loader request while the host stays quiet
  sequence boot_only_s;
    boot_clear && !host_write.valid;
  endsequence

  reset_value_a: assert property (
    @(posedge clk) reset |=> (sel == FN_SYNC) && !debug_access_enable &&
      (pin_function_register == 8'h80) && !pin_oe)
    else $error("select field not at sync function after reset");

  debug_gate_a: assert property (
    @(posedge clk) disable iff (reset)
    debug_access_enable == (sel == FN_TEST_CLOCK))
    else $error("debug access open while test clock not selected");

  field_place_a: assert property (
    @(posedge clk) disable iff (reset)
    (pin_function_register[SEL_MSB:SEL_LSB] == sel) &&
      (pin_function_register[SEL_LSB-1:0] == 6'h00))
    else $error("pin function register image does not match select field");

  clock_route_a: assert property (
    @(posedge clk) disable iff (reset)
    (settle_cnt == 2'h3) && (sel == FN_TEST_CLOCK) |->
      debug_test_clock == $past(pin_in, 3))
    else $error("test clock not routed from pin");

  capture_route_a: assert property (
    @(posedge clk) disable iff (reset)
    (settle_cnt == 2'h3) |->
      timer_capture_input == ((sel == FN_TIMER_CAPTURE) && $past(pin_in, 3)))
    else $error("timer capture routing wrong");

  sync_route_a: assert property (
    @(posedge clk) disable iff (reset)
    (settle_cnt == 2'h3) |-> sync_input == ((sel == FN_SYNC) && $past(pin_in, 3)))
    else $error("sync input routing wrong");

  pwm_drive_a: assert property (
    @(posedge clk) disable iff (reset)
    pin_oe == (sel == FN_PWM0) && (!pin_oe || pin_out == $past(pwm0_drive)))
    else $error("pin drive does not follow PWM channel zero");

  quiet_pin_a: assert property (
    @(posedge clk) disable iff (reset)
    (sel != FN_TEST_CLOCK) |-> !debug_test_clock && !debug_access_enable)
    else $error("test clock leaks while another function is selected");

  host_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    host_zero_s |=> debug_open_s)
    else $error("host clear of select field not accepted");

  boot_clear_a: assert property (
    @(posedge clk) disable iff (reset)
    boot_only_s |=> debug_open_s)
    else $error("boot loader clear of select field not accepted");

  host_first_a: assert property (
    @(posedge clk) disable iff (reset)
    host_write.valid |=> sel == $past(host_write.data[SEL_MSB:SEL_LSB]))
    else $error("host write lost to another source");

  // Pin released and quiet whenever PWM channel zero is not selected
  pin_release_a: assert property (
    @(posedge clk) disable iff (reset)
    !pin_oe |-> !pin_out)
    else $error("pin output active while the pin is released");

  // Select field only moves on an accepted write
  hold_value_a: assert property (
    @(posedge clk) disable iff (reset)
    !host_write.valid && !boot_clear && !app_write.valid |=> $stable(sel))
    else $error("select field changed without a write");

  app_write_a: assert property (
    @(posedge clk) disable iff (reset)
    app_write.valid && !host_write.valid && !boot_clear |=>
      sel == $past(app_write.data[SEL_MSB:SEL_LSB]))
    else $error("application write to select field not taken");

endmodule : tcpfs_top

// File: sim/tcpfs_pin_partner.sv
// Far-side model of the shared pin: external debugger or timing source
`timescale 1ns/10ps

module tcpfs_pin_partner (
  input  wire logic clk,
  input  wire logic pin_oe,
  input  wire logic pin_out,
  output wire logic pin_level
);
  logic [15:0] pattern;

  // ****************************************************************
  // Far-side drive
  // ****************************************************************
  initial pattern = 16'hACE1;
  // Test clock or sync pattern, stepped just after each edge so a new pseudo-random bit appears every cycle
  always @(posedge clk) begin
    pattern <= {pattern[14:0], pattern[15] ^ pattern[13] ^ pattern[12] ^ pattern[10]};
  end
  // Shared wire: device drives while its enable is high, otherwise the far side
  assign pin_level = pin_oe ? pin_out : pattern[0];
endmodule : tcpfs_pin_partner

// File: sim/tcpfs_bench.sv
// Self-checking bench for the test clock pin function select block
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module tcpfs_bench;
  import tcpfs_pkg::*;
  logic             clk, reset, boot_checksum_bad, pwm0_drive;
  tcpfs_wr_s        app_write, host_write;
  wire logic        pin_in;
  logic [REG_W-1:0] pin_function_register;
  logic             debug_access_enable, debug_test_clock, timer_capture_input;
  logic             sync_input, pin_out, pin_oe;
  int               seed = 21;
  int               miscompares = 0;
  int               check_count = 0;
  int               msel, age;
  bit               hist [3];
  logic             pwm_q;
  logic [31:0]      r;

  tcpfs_top u_dut (.clk(clk), .reset(reset), .app_write(app_write), .host_write(host_write),
    .boot_checksum_bad(boot_checksum_bad), .pwm0_drive(pwm0_drive), .pin_in(pin_in),
    .pin_function_register(pin_function_register), .debug_access_enable(debug_access_enable),
    .debug_test_clock(debug_test_clock), .timer_capture_input(timer_capture_input),
    .sync_input(sync_input), .pin_out(pin_out), .pin_oe(pin_oe));
  tcpfs_pin_partner u_far (.clk(clk), .pin_oe(pin_oe), .pin_out(pin_out), .pin_level(pin_in));

  // ****************************************************************
  // Clock, PWM source and reference model
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) pwm0_drive <= 1'($random(seed));
  // Model: host wins over boot clear, boot clear over application
  always @(posedge clk) begin
    hist[2] = hist[1];
    hist[1] = hist[0];
    hist[0] = pin_in;
    pwm_q   = pwm0_drive;
    age++;
    if (reset) begin
      msel = 2;
      age  = 0;
    end else if (host_write.valid) begin
      msel = host_write.data[7:6];
      age  = 0;
    end else if (boot_checksum_bad) begin
      msel = 0;
      age  = 0;
    end else if (app_write.valid) begin
      msel = app_write.data[7:6];
      age  = 0;
    end
  end
  // Compare every output with the model between edges
  always @(negedge clk) begin
    if (!reset) begin
      `CHK("register", {2'(msel), 6'h00}, pin_function_register)
      `CHK("debug enable", 1'(msel == 0), debug_access_enable)
      `CHK("pin enable", 1'(msel == 3), pin_oe)
      if (age >= 3) begin
        `CHK("test clock", (msel == 0) & hist[2], debug_test_clock)
        `CHK("capture", (msel == 1) & hist[2], timer_capture_input)
        `CHK("sync", (msel == 2) & hist[2], sync_input)
        `CHK("pin out", (msel == 3) & pwm_q, pin_out)
      end
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // One write pulse: 0 application, 1 host, otherwise boot clear
  task automatic wr(input int src, input logic [1:0] fn);
    logic [7:0] d;
    d = {fn, 6'($random(seed))};
    @(posedge clk);
    if (src == 0) app_write <= '{1'b1, d};
    else if (src == 1) host_write <= '{1'b1, d};
    else boot_checksum_bad <= 1'b1;
    @(posedge clk);
    app_write.valid   <= 1'b0;
    host_write.valid  <= 1'b0;
    boot_checksum_bad <= 1'b0;
  endtask : wr
  task automatic finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #(50 * 3000);
    miscompares++;
    finish_test();
  end
  initial begin
    reset = 1'b1;
    app_write = '0;
    host_write = '0;
    boot_checksum_bad = 1'b0;
    pwm0_drive = 1'b0;
    idle(10);
    reset <= 1'b0;
    idle(20); // No firmware write, so the field keeps its reset value
    @(negedge clk) `CHK("reset image", 8'h80, pin_function_register)
    $display("test reset done");
    for (int f = 0; f < 4; f++) begin
      wr(0, 2'(f)); // Every pin function in turn
      idle(20);
    end
    $display("test functions done");
    wr(0, 2'h2);
    wr(2, 2'h3); // Bad checksum reopens debug
    @(negedge clk) `CHK("boot clear", 1'b1, debug_access_enable)
    wr(0, 2'h3);
    @(posedge clk);
    host_write <= '{1'b1, 8'h3F};
    app_write  <= '{1'b1, 8'hC0};
    @(posedge clk);
    host_write.valid <= 1'b0;
    app_write.valid  <= 1'b0;
    @(negedge clk) `CHK("host clear", 8'h00, pin_function_register)
    $display("test clears done");
    repeat (300) begin
      @(posedge clk);
      r = $random(seed);
      app_write         <= '{r[0], r[15:8]};
      host_write        <= '{r[1] & r[2], r[23:16]};
      boot_checksum_bad <= r[3] & r[4];
    end
    @(posedge clk);
    app_write.valid   <= 1'b0;
    host_write.valid  <= 1'b0;
    boot_checksum_bad <= 1'b0;
    idle(5);
    $display("test random done");
    wr(1, 2'h0);
    reset <= 1'b1; // Reset in mid-run closes debug again
    idle(3);
    reset <= 1'b0;
    @(negedge clk) `CHK("second reset", 1'b0, debug_access_enable)
    idle(10);
    $display("test second reset done");
    finish_test();
  end
endmodule : tcpfs_bench
